// file: src/burner_consts.svh
`ifndef BURNER_CONSTS_SVH
`define BURNER_CONSTS_SVH

// function codes, coil values and exception answers
`define FC_READ_DISC    8'h02
`define FC_READ_HOLD    8'h03
`define FC_READ_INPUT   8'h04
`define FC_WRITE_COIL   8'h05
`define COIL_VALUE_ON   16'hFF00
`define COIL_VALUE_OFF  16'h0000
`define EXC_FLAG        8'h80
`define EXC_BAD_FUNC    8'h01
`define EXC_BAD_ADDR    8'h02
`define EXC_BAD_VALUE   8'h03
`define NO_BYTE         8'h00

// command coil addresses
`define COIL_P1_UP      16'h0008
`define COIL_P1_DOWN    16'h0009
`define COIL_P2_UP      16'h000A
`define COIL_P2_DOWN    16'h000B
`define COIL_HALT       16'h000C
`define COIL_RESUME     16'h000D

// discrete input addresses
`define DI_HALT_STATE   16'h0012
`define DI_DB_HIGH      16'h0021
`define DI_DB_LOW       16'h0022
`define DI_UNIT         16'h0023
`define DI_W40          16'h0024
`define DI_W20          16'h0025
`define DI_W10          16'h0026
`define DI_CAL2         16'h0027

// holding and input registers 0..3
`define REG_COUNT       16'h0004
`define REG_P1_C        16'h0000
`define REG_P2_C        16'h0001
`define REG_P1_F        16'h0002
`define REG_P2_F        16'h0003

// reduced drive weights in percent
`define WEIGHT_40       7'h28
`define WEIGHT_20       7'h14
`define WEIGHT_10       7'h0A

// deadband in degrees C for select pair 00, 01, 10, 11
`define DB_C_00         4'h5
`define DB_C_01         4'h3
`define DB_C_10         4'h2
`define DB_C_11         4'h1

// celsius to fahrenheit
`define F_MUL           32'sh0000_0009
`define F_DIV           32'sh0000_0005
`define F_OFFSET        32'sh0000_0020

`endif

// file: src/burner_pkg.sv
package burner_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HIGH = 3'b010,
        ST_LOW  = 3'b100
    } answer_state_t;

endpackage

// file: src/setpoint_stepper.sv
`timescale 1ns/1ps
`default_nettype none
`include "burner_consts.svh"

module setpoint_stepper #(
    parameter int          WIDTH    = 16,
    parameter logic [15:0] RESET_C  = 16'h0064,
    parameter logic [15:0] MIN_C    = 16'h0000,
    parameter logic [15:0] MAX_C    = 16'h03E8
) (
    input  wire logic              mclk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              step_up_in,
    input  wire logic              step_down_in,
    output logic [WIDTH-1:0]       celsius_out,
    output logic [WIDTH-1:0]       fahrenheit_out
);

    if (WIDTH != 16)
    begin : g_bad_width
        $error("setpoint_stepper: register width must be 16");
    end

    logic [WIDTH-1:0] celsius_r;
    logic [WIDTH-1:0] celsius_nxt;
    logic [WIDTH-1:0] fahrenheit_r;

    function automatic logic [WIDTH-1:0] to_fahrenheit(input logic [WIDTH-1:0] c);
        logic signed [31:0] wide;
        wide = 32'($signed(c)) * `F_MUL / `F_DIV + `F_OFFSET;
        return wide[WIDTH-1:0];
    endfunction

    // one step per command, clamped so a stuck master cannot wrap the value
    always_comb
    begin
        celsius_nxt = celsius_r;
        if (step_up_in && celsius_r < MAX_C)
            celsius_nxt = celsius_r + 16'h0001;
        else if (step_down_in && celsius_r > MIN_C)
            celsius_nxt = celsius_r - 16'h0001;
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            celsius_r <= RESET_C;
        else
            celsius_r <= celsius_nxt;
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            fahrenheit_r <= 16'h0000;
        else
            fahrenheit_r <= to_fahrenheit(celsius_nxt);
    end

    assign celsius_out    = celsius_r;
    assign fahrenheit_out = fahrenheit_r;

endmodule // setpoint_stepper

`default_nettype wire

// file: src/burner_safety_modbus_map.sv
// Overview of operation
// - deadband pair at 33,34 selects deadband
// - unit switch at 35, one means fahrenheit
// - active-low weight bits at 36,37,38
// - solenoid power is sum of enabled weights
// - input 39 flags second probe calibration
// - register answers are msb byte first
// - holding 0..3 hold the four setpoints
// - input registers 0..3 hold readings
// - only command coils act on writes
// - FF00 means on, 0000 means off
// - off value to command coil ignored
// - coils 8..11 step setpoints once
// - coil 12 on stops everything
// - switch off-then-on clears remote stop
// - coil 13 on clears remote stop
// - run still needs switches and closures
// - coil 12 on cancels remote start
// - discrete input 18 shows remote stop
`timescale 1ns/1ps
`default_nettype none
`include "burner_consts.svh"

module burner_safety_modbus_map #(
    parameter logic [15:0] P1_RESET_C = 16'h0064,
    parameter logic [15:0] P2_RESET_C = 16'h0064,
    parameter int          REG_WIDTH  = 16
) (
    input  wire logic                 mclk_in,
    input  wire logic                 sys_rst_in,
    // decoded request from the serial front end
    input  wire logic                 req_valid_in,
    output logic                      req_ready_out,
    input  wire logic [7:0]           req_func_in,
    input  wire logic [15:0]          req_addr_in,
    input  wire logic [15:0]          req_value_in,
    // answer bytes
    output logic                      resp_valid_out,
    output logic                      resp_last_out,
    output logic [7:0]                resp_byte_out,
    output logic                      resp_error_out,
    // configuration switches and probe status
    input  wire logic                 deadband_high_select_in,
    input  wire logic                 deadband_low_select_in,
    input  wire logic                 unit_select_in,
    input  wire logic                 weight_forty_n_in,
    input  wire logic                 weight_twenty_n_in,
    input  wire logic                 weight_ten_n_in,
    input  wire logic                 second_probe_cal_error_in,
    input  wire logic [REG_WIDTH-1:0] first_probe_celsius_in,
    input  wire logic [REG_WIDTH-1:0] second_probe_celsius_in,
    input  wire logic [REG_WIDTH-1:0] first_probe_fahrenheit_in,
    input  wire logic [REG_WIDTH-1:0] second_probe_fahrenheit_in,
    // run chain
    input  wire logic                 local_switch_in,
    input  wire logic                 remote_onoff_in,
    input  wire logic                 shutdown_ok_in,
    input  wire logic                 proof_of_closure_in,
    // outputs to the burner logic
    output logic [3:0]                deadband_celsius_out,
    output logic [4:0]                deadband_fahrenheit_out,
    output logic                      fahrenheit_display_out,
    output logic [6:0]                solenoid_power_pct_out,
    output logic                      reduced_drive_valve_mode_out,
    output logic                      remote_stop_out,
    output logic                      run_permit_out,
    output logic                      relays_enable_out,
    output logic                      ignition_power_out,
    output logic                      valves_open_enable_out,
    output logic [REG_WIDTH-1:0]      first_probe_setpoint_out,
    output logic [REG_WIDTH-1:0]      second_probe_setpoint_out
);

    if (REG_WIDTH != 16)
    begin : g_bad_width
        $error("burner_safety_modbus_map: register width must be 16");
    end

    ////////////////////////////////////////////////////////////////////////////////

    burner_pkg::answer_state_t st_r;
    burner_pkg::answer_state_t st_nxt;
    logic [15:0]               word_r;
    logic [15:0]               word_nxt;
    logic                      err_nxt;
    logic [7:0]                byte_r;
    logic                      err_r;
    logic                      accept;
    logic                      coil_on;
    logic                      coil_off;
    logic                      is_coil_write;
    logic                      step_p1_up;
    logic                      step_p1_down;
    logic                      step_p2_up;
    logic                      step_p2_down;
    logic                      halt_cmd;
    logic                      resume_cmd;
    logic                      halt_r;
    logic                      halt_nxt;
    logic                      local_prev_r;
    logic                      remote_prev_r;
    logic                      toggle_clear;
    logic                      permit_r;
    logic [6:0]                power_nxt;
    logic [6:0]                power_r;
    logic [3:0]                db_c_r;
    logic                      unit_r;
    logic [15:0]               sp1_c;
    logic [15:0]               sp1_f;
    logic [15:0]               sp2_c;
    logic [15:0]               sp2_f;

    function automatic logic [3:0] deadband_c(input logic hi, input logic lo);
        logic [3:0] v;
        unique case ({hi, lo})
            2'b00: v = `DB_C_00;
            2'b01: v = `DB_C_01;
            2'b10: v = `DB_C_10;
            2'b11: v = `DB_C_11;
        endcase
        return v;
    endfunction

    function automatic logic [15:0] bit_word(input logic b);
        return {15'h0000, b};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // request decode

    assign req_ready_out  = (st_r == burner_pkg::ST_IDLE);
    assign accept         = req_valid_in && req_ready_out;
    assign is_coil_write  = accept && req_func_in == `FC_WRITE_COIL;
    assign coil_on        = is_coil_write && req_value_in == `COIL_VALUE_ON;
    assign coil_off       = is_coil_write && req_value_in == `COIL_VALUE_OFF;

    // an off value matches none of these, so it changes nothing
    assign step_p1_up   = coil_on && req_addr_in == `COIL_P1_UP;
    assign step_p1_down = coil_on && req_addr_in == `COIL_P1_DOWN;
    assign step_p2_up   = coil_on && req_addr_in == `COIL_P2_UP;
    assign step_p2_down = coil_on && req_addr_in == `COIL_P2_DOWN;
    assign halt_cmd     = coil_on && req_addr_in == `COIL_HALT;
    assign resume_cmd   = coil_on && req_addr_in == `COIL_RESUME;

    ////////////////////////////////////////////////////////////////////////////////
    // answer word

    always_comb
    begin
        word_nxt = word_r;
        err_nxt  = 1'b0;
        unique case (req_func_in)
            `FC_READ_DISC:
            begin
                unique case (req_addr_in)
                    `DI_HALT_STATE: word_nxt = bit_word(halt_r);
                    `DI_DB_HIGH:    word_nxt = bit_word(deadband_high_select_in);
                    `DI_DB_LOW:     word_nxt = bit_word(deadband_low_select_in);
                    `DI_UNIT:       word_nxt = bit_word(unit_select_in);
                    `DI_W40:        word_nxt = bit_word(weight_forty_n_in);
                    `DI_W20:        word_nxt = bit_word(weight_twenty_n_in);
                    `DI_W10:        word_nxt = bit_word(weight_ten_n_in);
                    `DI_CAL2:       word_nxt = bit_word(second_probe_cal_error_in);
                    default:
                    begin
                        word_nxt = {`EXC_FLAG | req_func_in, `EXC_BAD_ADDR};
                        err_nxt  = 1'b1;
                    end
                endcase
            end
            `FC_READ_HOLD:
            begin
                unique case (req_addr_in)
                    `REG_P1_C: word_nxt = sp1_c;
                    `REG_P2_C: word_nxt = sp2_c;
                    `REG_P1_F: word_nxt = sp1_f;
                    `REG_P2_F: word_nxt = sp2_f;
                    default:
                    begin
                        word_nxt = {`EXC_FLAG | req_func_in, `EXC_BAD_ADDR};
                        err_nxt  = 1'b1;
                    end
                endcase
            end
            `FC_READ_INPUT:
            begin
                unique case (req_addr_in)
                    `REG_P1_C: word_nxt = first_probe_celsius_in;
                    `REG_P2_C: word_nxt = second_probe_celsius_in;
                    `REG_P1_F: word_nxt = first_probe_fahrenheit_in;
                    `REG_P2_F: word_nxt = second_probe_fahrenheit_in;
                    default:
                    begin
                        word_nxt = {`EXC_FLAG | req_func_in, `EXC_BAD_ADDR};
                        err_nxt  = 1'b1;
                    end
                endcase
            end
            `FC_WRITE_COIL:
            begin
                // state coils follow temperature; only commands are writable
                if (req_addr_in < `COIL_P1_UP || req_addr_in > `COIL_RESUME)
                begin
                    word_nxt = {`EXC_FLAG | req_func_in, `EXC_BAD_ADDR};
                    err_nxt  = 1'b1;
                end
                else if (!coil_on && !coil_off)
                begin
                    word_nxt = {`EXC_FLAG | req_func_in, `EXC_BAD_VALUE};
                    err_nxt  = 1'b1;
                end
                else
                    word_nxt = req_value_in;
            end
            default:
            begin
                word_nxt = {`EXC_FLAG | req_func_in, `EXC_BAD_FUNC};
                err_nxt  = 1'b1;
            end
        endcase
    end

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            burner_pkg::ST_IDLE: if (accept) st_nxt = burner_pkg::ST_HIGH;
            burner_pkg::ST_HIGH: st_nxt = burner_pkg::ST_LOW;
            burner_pkg::ST_LOW:  st_nxt = burner_pkg::ST_IDLE;
            default:             st_nxt = burner_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            st_r <= burner_pkg::ST_IDLE;
        else
            st_r <= st_nxt;
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            word_r <= 16'h0000;
            err_r  <= 1'b0;
        end
        else if (accept)
        begin
            word_r <= word_nxt;
            err_r  <= err_nxt;
        end
    end

    // high byte goes out first, then low
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            byte_r <= `NO_BYTE;
        else if (accept)
            byte_r <= word_nxt[15:8];
        else if (st_r == burner_pkg::ST_HIGH)
            byte_r <= word_r[7:0];
        else if (st_r == burner_pkg::ST_LOW)
            byte_r <= `NO_BYTE;
    end

    assign resp_valid_out = (st_r != burner_pkg::ST_IDLE);
    assign resp_last_out  = (st_r == burner_pkg::ST_LOW);
    assign resp_byte_out  = byte_r;
    assign resp_error_out = err_r && resp_valid_out;

    ////////////////////////////////////////////////////////////////////////////////
    // setpoints

    setpoint_stepper #(
        .WIDTH   (REG_WIDTH),
        .RESET_C (P1_RESET_C)
    ) u_first_probe_sp (
        .mclk_in        (mclk_in),
        .sys_rst_in     (sys_rst_in),
        .step_up_in     (step_p1_up),
        .step_down_in   (step_p1_down),
        .celsius_out    (sp1_c),
        .fahrenheit_out (sp1_f)
    );

    setpoint_stepper #(
        .WIDTH   (REG_WIDTH),
        .RESET_C (P2_RESET_C)
    ) u_second_probe_sp (
        .mclk_in        (mclk_in),
        .sys_rst_in     (sys_rst_in),
        .step_up_in     (step_p2_up),
        .step_down_in   (step_p2_down),
        .celsius_out    (sp2_c),
        .fahrenheit_out (sp2_f)
    );

    assign first_probe_setpoint_out  = sp1_c;
    assign second_probe_setpoint_out = sp2_c;

    ////////////////////////////////////////////////////////////////////////////////
    // remote stop latch and run chain

    // prev flops reset low: a switch already on at release shows as a toggle, which can only clear
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            local_prev_r  <= 1'b0;
            remote_prev_r <= 1'b0;
        end
        else
        begin
            local_prev_r  <= local_switch_in;
            remote_prev_r <= remote_onoff_in;
        end
    end

    // off then on again shows as a rising edge
    assign toggle_clear = (local_switch_in && !local_prev_r)
                        || (remote_onoff_in && !remote_prev_r);

    // a stop command wins over a clear in the same cycle: failing safe
    always_comb
    begin
        halt_nxt = halt_r;
        if (resume_cmd || toggle_clear)
            halt_nxt = 1'b0;
        if (halt_cmd)
            halt_nxt = 1'b1;
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            halt_r <= 1'b0;
        else
            halt_r <= halt_nxt;
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            permit_r <= 1'b0;
        else
            permit_r <= !halt_nxt && local_switch_in && remote_onoff_in
                        && shutdown_ok_in && proof_of_closure_in;
    end

    assign remote_stop_out        = halt_r;
    assign run_permit_out         = permit_r;
    assign relays_enable_out      = permit_r;
    assign ignition_power_out     = permit_r;
    assign valves_open_enable_out = permit_r;

    ////////////////////////////////////////////////////////////////////////////////
    // switch decode

    always_comb
    begin
        power_nxt = 7'h00;
        if (!weight_forty_n_in)
            power_nxt = power_nxt + `WEIGHT_40;
        if (!weight_twenty_n_in)
            power_nxt = power_nxt + `WEIGHT_20;
        if (!weight_ten_n_in)
            power_nxt = power_nxt + `WEIGHT_10;
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            power_r <= 7'h00;
            db_c_r  <= `DB_C_00;
            unit_r  <= 1'b0;
        end
        else
        begin
            power_r <= power_nxt;
            db_c_r  <= deadband_c(deadband_high_select_in, deadband_low_select_in);
            unit_r  <= unit_select_in;
        end
    end

    // fahrenheit deadband is twice the celsius one
    assign deadband_celsius_out         = db_c_r;
    assign deadband_fahrenheit_out      = {db_c_r, 1'b0};
    assign fahrenheit_display_out       = unit_r;
    assign solenoid_power_pct_out       = power_r;
    assign reduced_drive_valve_mode_out = (power_r != 7'h00);

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_halt_sets: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        halt_cmd |=> halt_r && !run_permit_out ##1 !relays_enable_out)
        else $error("stop command did not latch");

    a_halt_blocks: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        halt_r |-> !run_permit_out && !ignition_power_out && !valves_open_enable_out)
        else $error("run allowed while stopped");

    a_resume_clears: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        resume_cmd && !halt_cmd |=> !halt_r)
        else $error("start command did not clear stop");

    a_toggle_clears: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !local_prev_r && local_switch_in && !halt_cmd |=> !remote_stop_out)
        else $error("switch toggle did not clear stop");

    a_halt_holds: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        halt_r && !resume_cmd && !toggle_clear |=> halt_r)
        else $error("stop latch dropped by itself");

    a_off_ignored: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        coil_off && !toggle_clear |=> $stable(halt_r) && $stable(sp1_c) && $stable(sp2_c))
        else $error("off value changed state");

    a_step_once: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        step_p1_up && sp1_c < 16'h03E8 |=> sp1_c == $past(sp1_c) + 16'h0001)
        else $error("setpoint did not step by one");

    a_run_blocked: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !shutdown_ok_in || !proof_of_closure_in |=> !run_permit_out)
        else $error("run allowed with chain open");

    a_msb_first: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        accept |=> resp_valid_out && resp_byte_out == word_r[15:8]
                   ##1 resp_last_out && resp_byte_out == word_r[7:0])
        else $error("answer bytes out of order");

    a_hold_map: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        accept && req_func_in == `FC_READ_HOLD && req_addr_in == `REG_P1_F
        |=> word_r == sp1_f && !err_r)
        else $error("holding register map wrong");

    a_power_sum: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !weight_twenty_n_in && !weight_ten_n_in && weight_forty_n_in
        |=> solenoid_power_pct_out == 7'h1E)
        else $error("solenoid power not the weight sum");

    a_deadband_map: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        deadband_high_select_in && deadband_low_select_in
        |=> deadband_celsius_out == 4'h1 && deadband_fahrenheit_out == 5'h02)
        else $error("deadband decode wrong");

    a_state_coil: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        is_coil_write && req_addr_in < `COIL_P1_UP |=> err_r && $stable(halt_r))
        else $error("state coil write accepted");

endmodule // burner_safety_modbus_map

`default_nettype wire

// file: verification/modbus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
    input  wire logic        mclk_in,
    input  wire logic        resp_error_in,
    input  wire logic [7:0]  resp_byte_in,
    output logic             req_valid_out,
    output logic [7:0]       req_func_out,
    output logic [15:0]      req_addr_out,
    output logic [15:0]      req_value_out
);
    logic [15:0] word_r;
    logic        err_r;
    initial {req_valid_out, req_func_out, req_addr_out, req_value_out} = '0;
    // one request in flight; the answer is read before the next, so spacing always holds
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] v);
        @(posedge mclk_in);
        #1;
        req_valid_out = 1'b1;
        req_func_out = f;
        req_addr_out = a;
        req_value_out = v;
        @(posedge mclk_in);
        #1;
        req_valid_out = 1'b0;
        // released lines show the inverse, never a stale copy
        req_func_out = ~f;
        req_addr_out = ~a;
        req_value_out = ~v;
        word_r[15:8] = resp_byte_in;
        err_r = resp_error_in;
        @(posedge mclk_in);
        #1;
        word_r[7:0] = resp_byte_in;
    endtask
endmodule // modbus_master_model
`default_nettype wire

// file: verification/burner_safety_modbus_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module burner_safety_modbus_map_tb_top;
    logic        mclk_in = 1'b0, sys_rst_in = 1'b1, req_valid_in, resp_error_out;
    logic        fahrenheit_display_out, reduced_drive_valve_mode_out, remote_stop_out;
    logic        run_permit_out, relays_enable_out, ignition_power_out, valves_open_enable_out;
    logic [7:0]  req_func_in, resp_byte_out;
    logic [15:0] req_addr_in, req_value_in, first_probe_setpoint_out, second_probe_setpoint_out;
    logic [3:0]  deadband_celsius_out, chain = 4'hF;
    logic [4:0]  deadband_fahrenheit_out;
    logic [6:0]  solenoid_power_pct_out, sw = 7'h00, p;
    logic [15:0] rd [4] = '{default: 16'h0000};
    logic [15:0] seed = 16'h0041;
    logic [3:0]  dbt [4] = '{4'h5, 4'h3, 4'h2, 4'h1};
    int          err_total = 0, cmp_count = 0, cyc = 0;
    always #10 mclk_in = ~mclk_in;
    burner_safety_modbus_map dut (.*, .req_ready_out(), .resp_valid_out(), .resp_last_out(),
        .deadband_high_select_in(sw[6]), .deadband_low_select_in(sw[5]),
        .unit_select_in(sw[4]), .weight_forty_n_in(sw[3]), .weight_twenty_n_in(sw[2]),
        .weight_ten_n_in(sw[1]), .second_probe_cal_error_in(sw[0]),
        .first_probe_celsius_in(rd[0]), .second_probe_celsius_in(rd[1]),
        .first_probe_fahrenheit_in(rd[2]), .second_probe_fahrenheit_in(rd[3]),
        .local_switch_in(chain[3]), .remote_onoff_in(chain[2]),
        .shutdown_ok_in(chain[1]), .proof_of_closure_in(chain[0]));
    modbus_master_model m (.mclk_in(mclk_in), .resp_error_in(resp_error_out),
        .resp_byte_in(resp_byte_out), .req_valid_out(req_valid_in),
        .req_func_out(req_func_in), .req_addr_out(req_addr_in), .req_value_out(req_value_in));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nx(input logic [15:0] x);
        x ^= x << 7;
        x ^= x >> 9;
        return x ^ (x << 8);
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge mclk_in);
        #1 sys_rst_in = 1'b0;
        for (int k = 0; k < 10; k++)
        begin
            seed = nx(seed);
            sw = (k == 0) ? 7'h7F : (k == 1) ? 7'h00 : seed[6:0];
            for (int i = 0; i < 4; i++)
                rd[i] = nx(seed + 16'(i));
            p = (sw[3] ? 7'h00 : 7'h28) + (sw[2] ? 7'h00 : 7'h14) + (sw[1] ? 7'h00 : 7'h0A);
            repeat (3) @(posedge mclk_in);
            chk("db_c", dbt[sw[6:5]], deadband_celsius_out);
            chk("db_f", {dbt[sw[6:5]], 1'b0}, deadband_fahrenheit_out);
            chk("unit", sw[4], fahrenheit_display_out);
            chk("power", p, solenoid_power_pct_out);
            chk("mode", p != 7'h00, reduced_drive_valve_mode_out);
            for (int a = 0; a < 7; a++)
            begin
                m.xfer(8'h02, 16'h0021 + 16'(a), 16'h0000);
                chk("disc", sw[6 - a], m.word_r);
            end
            for (int i = 0; i < 4; i++)
            begin
                m.xfer(8'h04, 16'(i), 16'h0000);
                chk("input_reg", rd[i], m.word_r);
            end
        end
        $display("test switches done");
        m.xfer(8'h03, 16'h0002, 16'h0000);
        chk("hold2", 16'h00D4, m.word_r);
        m.xfer(8'h05, 16'h0008, 16'hFF00);
        chk("echo", 16'hFF00, m.word_r);
        m.xfer(8'h03, 16'h0002, 16'h0000);
        chk("hold2_up", 16'h00D5, m.word_r);
        m.xfer(8'h05, 16'h0009, 16'h0000);
        chk("off_ignored", 16'h0065, first_probe_setpoint_out);
        m.xfer(8'h05, 16'h000B, 16'hFF00);
        m.xfer(8'h03, 16'h0001, 16'h0000);
        chk("hold1_down", 16'h0063, m.word_r);
        chk("sp2_out", 16'h0063, second_probe_setpoint_out);
        m.xfer(8'h05, 16'h0001, 16'hFF00);
        chk("state_coil", 1'b1, m.err_r);
        m.xfer(8'h05, 16'h0008, 16'h1234);
        chk("bad_value", 1'b1, m.err_r);
        chk("no_step", 16'h0065, first_probe_setpoint_out);
        $display("test setpoints done");
        for (int t = 0; t < 2; t++)
        begin
            m.xfer(8'h05, 16'h000C, 16'hFF00);
            m.xfer(8'h05, 16'h000D, 16'h0000);
            m.xfer(8'h02, 16'h0012, 16'h0000);
            chk("stop_bit", 16'h0001, m.word_r);
            chk("ign_off", 1'b0, ignition_power_out | valves_open_enable_out);
            chk("relay_off", 1'b0, relays_enable_out | run_permit_out);
            if (t == 0)
                m.xfer(8'h05, 16'h000D, 16'hFF00);
            else
                chain[3 - seed[0]] = 1'b0;
            repeat (2) @(posedge mclk_in);
            #1 chain = 4'hF;
            repeat (3) @(posedge mclk_in);
            chk("cleared", 1'b0, remote_stop_out);
            chk("permit", 1'b1, run_permit_out);
        end
        #1 chain[0] = 1'b0;
        repeat (3) @(posedge mclk_in);
        chk("closure_open", 1'b0, run_permit_out);
        $display("test remote stop done");
        wrap_up();
    end
endmodule // burner_safety_modbus_map_tb_top
`default_nettype wire
